// [iobad_pkg.sv]
// constants, field layouts and carriers of the I/O base address decoder
// assumes a 40 MHz system clock and a 32-bit classic Wishbone master
package iobad_pkg;

    // ========================================================
    // host address layout
    localparam int           IOBAD_ADDR_W    = 10;
    localparam int           IOBAD_BASE_LSB  = 5;
    localparam int           IOBAD_IDX_W     = 5;
    localparam logic [4:0]   BASE_SW_DEFAULT = 5'h11;   // base 220 hex
    localparam logic [9:0]   WIN_LO_DEFAULT  = 10'h220;
    localparam logic [9:0]   WIN_HI_DEFAULT  = 10'h23F;

    // ========================================================
    // resource codes
    localparam logic [1:0]   DMA_NONE        = 2'h0;
    localparam logic [1:0]   DMA_CH5         = 2'h1;
    localparam logic [1:0]   DMA_CH6         = 2'h2;
    localparam logic [1:0]   DMA_CH7         = 2'h3;
    localparam int           DMA_LINES       = 3;
    localparam int           IRQ_LINES       = 16;
    localparam logic [3:0]   IRQ_MIO_DEFAULT = 4'hA;
    localparam logic [3:0]   IRQ_DIO_DEFAULT = 4'h5;
    localparam logic [15:0]  IRQ_MIO_OK      = 16'hDEF8;
    localparam logic [15:0]  IRQ_DIO_OK      = 16'h02F8;
    localparam logic [2:0]   PC_BIT_DEFAULT  = 3'h4;

    // ========================================================
    // wishbone register map (byte addresses)
    localparam logic [3:0]   WB_CTRL         = 4'h0;
    localparam logic [3:0]   WB_ROUTE        = 4'h4;
    localparam logic [3:0]   WB_STAT         = 4'h8;
    localparam int           CTRL_DEC_EN     = 0;
    localparam int           CTRL_JMP        = 1;
    localparam logic [1:0]   CTRL_RESET      = 2'h1;
    localparam logic [15:0]  ROUTE_RESET     = 16'h45AE;

    // resource routing, same layout for the jumper pins and ROUTE register
    typedef struct packed
    {
        logic       clk_src;    // 0 on-board oscillator, 1 sync bus clock
        logic [2:0] pc_bit;     // port C bit used as dio interrupt enable
        logic [3:0] dio_irq;
        logic [3:0] mio_irq;
        logic [1:0] dma2;
        logic [1:0] dma1;
    } iobad_route_s;

    // host side pins, all asynchronous to clk
    typedef struct packed
    {
        logic [9:0]  sa;
        logic        aen;
        logic        ior_n;
        logic        iow_n;
        logic [15:0] sd;
        logic [2:0]  dack_n;    // channels 7..5
        logic [7:0]  pc;
        logic        osc;
        logic        bus_clk;
    } iobad_hpin_s;

endpackage : iobad_pkg

// [iobad_top.sv]
// host I/O window decode and resource routing of the acquisition board
// assumes host pins are asynchronous and are synchronised here
`timescale 1ns/1ps
module iobad_top
    import iobad_pkg::*;
(
    input  wire logic         clk,                      // 40 MHz
    input  wire logic         resetn,                   // async, low
    input  wire iobad_hpin_s  hpin,                     // host bus pins
    input  wire logic [4:0]   base_address_switch_bank, // 1 = OFF side
    input  wire logic [3:0]   dma_channel_jumper,       // {dma2,dma1}
    input  wire logic [7:0]   irq_level_jumper,         // {dio,mio}
    input  wire logic [2:0]   dio_irq_enable_jumper,    // port C bit
    input  wire logic         timer_clock_select_jumper,// clock source
    input  wire logic [15:0]  reg_rdata,                // register data
    input  wire logic [1:0]   dma_req,                  // path requests
    input  wire logic         mio_irq_req,              // mio interrupt
    input  wire logic         dio_irq_req,              // dio interrupt
    output logic [15:0]       sd_o,                     // host data out
    output logic              sd_oe,                    // host data enable
    output logic [4:0]        reg_idx,                  // register index
    output logic              reg_rd,                   // read pulse
    output logic              reg_wr,                   // write pulse
    output logic [15:0]       reg_wdata,                // write data
    output logic [1:0]        dma_ack,                  // path acks
    output logic [2:0]        drq_o,                    // drq 7..5 out
    output logic [2:0]        drq_oe,                   // drq enables
    output logic [15:0]       irq_o,                    // irq lines out
    output logic [15:0]       irq_oe,                   // irq enables
    output logic              timer_clk,                // counter clock
    output logic              sync_clk_o,               // sync bus clock
    output logic              sync_clk_oe,              // sync clock enable
    input  wire logic         wb_cyc_i,                 // wishbone cycle
    input  wire logic         wb_stb_i,                 // wishbone strobe
    input  wire logic         wb_we_i,                  // write enable
    input  wire logic [3:0]   wb_adr_i,                 // byte address
    input  wire logic [3:0]   wb_sel_i,                 // byte lanes
    input  wire logic [31:0]  wb_dat_i,                 // write data
    output logic [31:0]       wb_dat_o,                 // read data
    output logic              wb_ack_o                  // acknowledge
);

    // ========================================================
    // pin synchronisers
    iobad_hpin_s   hp_s1;
    iobad_hpin_s   hp_s2;
    logic [4:0]    sw_s1;
    logic [4:0]    sw_s2;
    iobad_route_s  jmp_s1;
    iobad_route_s  jmp_s2;
    iobad_route_s  jmp_raw;

    assign jmp_raw = {timer_clock_select_jumper, dio_irq_enable_jumper,
                      irq_level_jumper[7:4], irq_level_jumper[3:0],
                      dma_channel_jumper[3:2], dma_channel_jumper[1:0]};

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            hp_s1  <= '1;
            hp_s2  <= '1;
            sw_s1  <= '0;
            sw_s2  <= '0;
            jmp_s1 <= '0;
            jmp_s2 <= '0;
        end
        else
        begin
            hp_s1  <= hpin;
            hp_s2  <= hp_s1;
            sw_s1  <= base_address_switch_bank;
            sw_s2  <= sw_s1;
            jmp_s1 <= jmp_raw;
            jmp_s2 <= jmp_s1;
        end
    end

    // ========================================================
    // control registers
    logic [1:0]    ctrl;
    iobad_route_s  route;
    iobad_route_s  act;

    // jumper mode off keeps the factory routing after reset
    assign act = ctrl[CTRL_JMP] ? jmp_s2 : route;

    // ========================================================
    // address decode
    wire        base_match = (hp_s2.sa[9:5] == sw_s2);
    wire        hit        = ctrl[CTRL_DEC_EN] && !hp_s2.aen && base_match;
    wire        rd_act     = hit && !hp_s2.ior_n;
    wire        wr_act     = hit && !hp_s2.iow_n;
    logic       rd_q;
    logic       wr_q;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_q      <= 1'b0;
            wr_q      <= 1'b0;
            reg_rd    <= 1'b0;
            reg_wr    <= 1'b0;
            reg_idx   <= '0;
            reg_wdata <= '0;
            sd_o      <= '0;
            sd_oe     <= 1'b0;
        end
        else
        begin
            rd_q      <= rd_act;
            wr_q      <= wr_act;
            reg_rd    <= rd_act && !rd_q;
            reg_wr    <= wr_act && !wr_q;
            reg_idx   <= hp_s2.sa[4:0];
            reg_wdata <= hp_s2.sd;
            sd_o      <= reg_rdata;
            sd_oe     <= rd_act;
        end
    end

    // ========================================================
    // dma routing; two-bit codes can only name channels 5..7
    logic [2:0] next_drq;
    logic [2:0] next_drq_oe;
    wire        ack1 = (act.dma1 != DMA_NONE)
                       && !hp_s2.dack_n[2'(act.dma1 - 2'h1)];
    wire        ack2 = (act.dma2 != DMA_NONE)
                       && !hp_s2.dack_n[2'(act.dma2 - 2'h1)];

    for (genvar k = 0; k < DMA_LINES; k++)
    begin : g_dma
        wire p1 = (act.dma1 == 2'(k + 1));
        wire p2 = (act.dma2 == 2'(k + 1));
        assign next_drq[k]    = (p1 && dma_req[0]) || (p2 && dma_req[1]);
        assign next_drq_oe[k] = p1 || p2;
    end

    // ========================================================
    // interrupt routing; a line is enabled only while asserting it
    logic [15:0] next_irq_oe;
    wire         dio_en = hp_s2.pc[act.pc_bit];

    for (genvar i = 0; i < IRQ_LINES; i++)
    begin : g_irq
        wire mio_sel = (act.mio_irq == 4'(i)) && IRQ_MIO_OK[i];
        wire dio_sel = (act.dio_irq == 4'(i)) && IRQ_DIO_OK[i];
        assign next_irq_oe[i] = (mio_sel && mio_irq_req)
                                || (dio_sel && dio_irq_req && dio_en);
    end

    // clock source: slow clocks only, both pass the synchronisers
    wire next_timer_clk = act.clk_src ? hp_s2.bus_clk : hp_s2.osc;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dma_ack     <= '0;
            drq_o       <= '0;
            drq_oe      <= '0;
            irq_o       <= '0;
            irq_oe      <= '0;
            timer_clk   <= 1'b0;
            sync_clk_o  <= 1'b0;
            sync_clk_oe <= 1'b0;
        end
        else
        begin
            dma_ack     <= {ack2, ack1};
            drq_o       <= next_drq;
            drq_oe      <= next_drq_oe;
            irq_o       <= next_irq_oe;
            irq_oe      <= next_irq_oe;
            timer_clk   <= next_timer_clk;
            sync_clk_o  <= hp_s2.osc;
            sync_clk_oe <= !act.clk_src;
        end
    end

    // ========================================================
    // wishbone slave, ack one cycle after the strobe
    // a write lands on the edge at which the master sees ack
    wire        wb_go  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire        wb_wr  = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
    wire [31:0] stat   = {20'h0, !hp_s2.ior_n, hit, reg_idx, sw_s2};
    wire [31:0] rd_mux = (wb_adr_i == WB_CTRL)  ? {30'h0, ctrl} :
                         (wb_adr_i == WB_ROUTE) ? {16'h0, route} :
                         (wb_adr_i == WB_STAT)  ? stat : 32'h0;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            ctrl     <= CTRL_RESET;
            route    <= ROUTE_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end
        else
        begin
            wb_ack_o <= wb_go;
            wb_dat_o <= wb_go ? rd_mux : 32'h0;
            if (wb_wr && wb_adr_i == WB_CTRL && wb_sel_i[0])
                ctrl <= wb_dat_i[1:0];
            if (wb_wr && wb_adr_i == WB_ROUTE && wb_sel_i[0])
                route[7:0] <= wb_dat_i[7:0];
            if (wb_wr && wb_adr_i == WB_ROUTE && wb_sel_i[1])
                route[15:8] <= wb_dat_i[15:8];
        end
    end

    // ========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_MATCH_DRIVE: assert property (sd_oe |-> $past(hp_s2.sa[9:5])
        == $past(sw_s2) && !$past(hp_s2.aen)) else $error("drive off window");
    AST_SW_LEVEL: assert property (reg_rd |-> $past(sw_s2)
        == $past(hp_s2.sa[9:5])) else $error("switch level mismatch");
    AST_INDEX: assert property (rd_act && !rd_q |=> reg_rd
        && reg_idx == $past(hp_s2.sa[4:0])) else $error("index wrong");
    AST_DEF_WIN: assert property (sw_s2 == BASE_SW_DEFAULT && sd_oe
        |-> $past(hp_s2.sa) >= WIN_LO_DEFAULT
        && $past(hp_s2.sa) <= WIN_HI_DEFAULT) else $error("window off");
    AST_MIO_IRQ: assert property (mio_irq_req && act.mio_irq
        == IRQ_MIO_DEFAULT |=> irq_oe[10] && irq_o[10])
        else $error("irq 10 not driven");
    AST_DMA6: assert property (dma_req[0] && act.dma1 == DMA_CH6
        |=> drq_o[1] && drq_oe[1]) else $error("dma 6 not driven");
    AST_CLK: assert property ($past(resetn) |-> timer_clk
        == $past(next_timer_clk)) else $error("timer clock source wrong");
    AST_NO8: assert property (dma_ack[0] |-> $past(act.dma1)
        != DMA_NONE) else $error("ack without channel");
    AST_IRQ_OK: assert property ((irq_oe & ~IRQ_MIO_OK) == 16'h0)
        else $error("unsupported irq driven");
    AST_NO_DRIVE: assert property (!rd_act |=> !sd_oe)
        else $error("data driven without read");
    AST_WB_ACK: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");

    COV_READ: cover property (rd_act ##1 sd_oe ##1 sd_oe);
    COV_WRITE: cover property (reg_wr);
    COV_JMP: cover property (ctrl[CTRL_JMP] && |irq_oe);
    COV_WB: cover property (wb_go && wb_we_i ##1 wb_wr);

endmodule : iobad_top

// [iobad_host_model.sv]
// host processor model: drives the host pin bundle of the decoder
// assumes tasks are called right after a rising edge of the bench clock
`timescale 1ns/1ps
module iobad_host_model
    import iobad_pkg::*;
(
    input  wire logic  clk,   // bench clock, strobes change after it
    output iobad_hpin_s hpin  // host pins toward the decoder
);
    // ========================================
    // idle: strobes high, no dma acknowledge
    initial
    begin
        hpin = '0;
        hpin.sa = 10'h3FF;
        hpin.ior_n = 1'b1;
        hpin.iow_n = 1'b1;
        hpin.dack_n = 3'h7;
    end

    task automatic strobe(input logic [9:0] a, input logic rd,
                          input logic dma, input logic [15:0] d);
        hpin.sa <= a;
        hpin.aen <= dma;
        hpin.sd <= d;
        if (rd)
            hpin.ior_n <= 1'b0;
        else
            hpin.iow_n <= 1'b0;
    endtask : strobe

    task automatic release_bus;
        hpin.ior_n <= 1'b1;
        hpin.iow_n <= 1'b1;
        hpin.aen <= 1'b0;
        // a released bus must not keep showing the last word
        hpin.sd <= ~hpin.sd;
    endtask : release_bus

    task automatic set_misc(input logic [7:0] p, input logic o,
                            input logic b);
        hpin.pc <= p;
        hpin.osc <= o;
        hpin.bus_clk <= b;
    endtask : set_misc

    task automatic set_dack(input logic [2:0] n);
        hpin.dack_n <= n;
    endtask : set_dack
endmodule : iobad_host_model

// [test_io_base_address_decoder.sv]
// self-checking bench of the I/O base address decoder
// assumes the host model file and the design package are compiled first
`timescale 1ns/1ps
module test_io_base_address_decoder;
    import iobad_pkg::*;
    logic clk = 1'b0, resetn = 1'b0, tsel = 1'b0;
    logic [4:0] sw = BASE_SW_DEFAULT;
    logic [3:0] dmaj = 4'h0, wb_adr = 4'h0, wb_sel = 4'hF;
    logic [7:0] irqj = 8'h00;
    logic [2:0] pcj = 3'h0, drq_o, drq_oe;
    logic [15:0] rdat = 16'hC3A5, sd_o, wdat, irq_o, irq_oe;
    logic [1:0] dreq = 2'h0, dack;
    logic mreq = 1'b0, dreq_io = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0;
    logic wb_we = 1'b0, wb_ack_o, sd_oe, rd, wr, tclk, sclk, sclk_oe;
    logic [31:0] wb_dat = '0, wb_dat_o, q;
    logic [4:0] idx;
    int n_fail = 0, comparisons = 0;
    iobad_hpin_s hpin;

    always #12.5 clk = ~clk;
    iobad_host_model host (.clk(clk), .hpin(hpin));
    iobad_top DUT (.clk(clk), .resetn(resetn), .hpin(hpin),
        .base_address_switch_bank(sw), .dma_channel_jumper(dmaj),
        .irq_level_jumper(irqj), .dio_irq_enable_jumper(pcj),
        .timer_clock_select_jumper(tsel), .reg_rdata(rdat),
        .dma_req(dreq), .mio_irq_req(mreq), .dio_irq_req(dreq_io),
        .sd_o(sd_o), .sd_oe(sd_oe), .reg_idx(idx), .reg_rd(rd),
        .reg_wr(wr), .reg_wdata(wdat), .dma_ack(dack), .drq_o(drq_o),
        .drq_oe(drq_oe), .irq_o(irq_o), .irq_oe(irq_oe),
        .timer_clk(tclk), .sync_clk_o(sclk), .sync_clk_oe(sclk_oe),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));

    // ========================================
    // shared checks and bus cycles
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [3:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        chk(wb_ack_o, 1, "wb ack");
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk);
    endtask : wb

    task automatic hrd(input logic [9:0] a, input logic dma,
                       input logic hit);
        host.strobe(a, 1'b1, dma, 16'h0000);
        repeat (4) @(posedge clk);
        chk(rd, hit, "read pulse");
        @(posedge clk);
        chk(rd, 0, "read pulse ends");
        chk(sd_oe, hit, "read enable");
        if (hit)
        begin
            chk(sd_o, rdat, "read data");
            chk(idx, a[4:0], "index");
        end
        host.release_bus();
        repeat (5) @(posedge clk);
        chk(sd_oe, 0, "bus released");
    endtask : hrd

    task automatic settle;
        repeat (5) @(posedge clk);
    endtask : settle

    // ========================================
    // scenarios
    task automatic t_regs;
        wb(1'b0, WB_CTRL, '0);
        chk(q, 32'h1, "ctrl reset");
        wb(1'b0, WB_ROUTE, '0);
        chk(q, 32'h45AE, "route reset");
        wb_sel <= 4'h1;
        wb(1'b1, WB_ROUTE, 32'h0000_1234);
        wb_sel <= 4'hF;
        wb(1'b0, WB_ROUTE, '0);
        chk(q, 32'h4534, "route low lane only");
        wb(1'b1, WB_ROUTE, {16'h0, ROUTE_RESET});
        wb(1'b0, WB_ROUTE, '0);
        chk(q, 32'h45AE, "route restored");
        wb(1'b0, WB_STAT, '0);
        chk(q[4:0], BASE_SW_DEFAULT, "stat switches");
        wb(1'b1, 4'hC, 32'hFFFF);
        wb(1'b0, 4'hC, '0);
        chk(q, 0, "unmapped");
    endtask : t_regs

    task automatic t_window;
        hrd(10'h220, 1'b0, 1'b1);
        hrd(10'h23F, 1'b0, 1'b1);
        hrd(10'h240, 1'b0, 1'b0);
        hrd(10'h21F, 1'b0, 1'b0);
        hrd(10'h225, 1'b1, 1'b0);
        host.strobe(10'h22A, 1'b0, 1'b0, 16'h5AC3);
        repeat (4) @(posedge clk);
        chk(wr, 1, "write pulse");
        @(posedge clk);
        chk(wr, 0, "write pulse ends");
        chk(wdat, 16'h5AC3, "write data");
        chk(idx, 5'h0A, "write index");
        host.release_bus();
        settle();
    endtask : t_window

    task automatic t_switch;
        sw <= 5'h1F;
        settle();
        hrd(10'h3E7, 1'b0, 1'b1);
        hrd(10'h227, 1'b0, 1'b0);
        sw <= 5'h00;
        settle();
        hrd(10'h00A, 1'b0, 1'b1);
        sw <= BASE_SW_DEFAULT;
    endtask : t_switch

    task automatic t_route;
        dreq <= 2'b11;
        mreq <= 1'b1;
        dreq_io <= 1'b1;
        host.set_misc(8'h10, 1'b1, 1'b0);
        settle();
        chk(drq_oe, 3'b110, "dma defaults");
        chk(drq_o, 3'b110, "dma requests");
        chk(irq_oe, 16'h0420, "irq defaults");
        chk(sclk_oe, 1, "sync clock driven");
        chk(tclk, 1, "timer follows osc");
        chk(sclk, 1, "sync clock follows osc");
        chk(irq_o, 16'h0420, "irq lines driven high");
        host.set_dack(3'b101);
        settle();
        chk(dack, 2'b01, "dma path one ack");
        host.set_dack(3'b011);
        settle();
        chk(dack, 2'b10, "dma path two ack");
        host.set_dack(3'b111);
        host.set_misc(8'hEF, 1'b0, 1'b1);
        settle();
        chk(irq_oe, 16'h0400, "dio gated");
        chk(tclk, 0, "timer osc low");
        chk(sclk, 0, "sync clock low");
        chk(dack, 2'b00, "no dma ack");
    endtask : t_route

    task automatic t_jumper;
        dmaj <= 4'b1101;
        irqj <= 8'h3F;
        pcj <= 3'h0;
        tsel <= 1'b1;
        dreq <= 2'b01;
        dreq_io <= 1'b0;
        wb(1'b1, WB_CTRL, 32'h3);
        settle();
        chk(drq_oe, 3'b101, "dma jumper");
        chk(drq_o, 3'b001, "dma ch5");
        chk(irq_oe, 16'h8000, "irq jumper");
        chk(tclk, 1, "timer bus clock");
        chk(sclk_oe, 0, "sync clock input");
        host.set_dack(3'b110);
        settle();
        chk(dack, 2'b01, "dma ch5 ack");
        host.set_dack(3'b111);
        settle();
    endtask : t_jumper

    task automatic t_reset;
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        chk(irq_oe, 16'h0, "irq idle in reset");
        chk(drq_oe, 3'h0, "dma idle in reset");
        chk(sd_oe, 0, "data idle in reset");
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        wb(1'b0, WB_CTRL, '0);
        chk(q, {30'h0, CTRL_RESET}, "ctrl after reset");
        chk(irq_oe, 16'h0400, "factory irq after reset");
        chk(drq_o, 3'b010, "dma path one after reset");
    endtask : t_reset

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict

    initial
    begin
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_window();
        t_switch();
        t_route();
        t_jumper();
        t_reset();
        print_verdict();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
endmodule : test_io_base_address_decoder
